// ===== core/pdsc_top.sv
// Pole-dead detection and system checks (live/dead, two sync stages, split alarm)
// Notes on behaviour
// RULE1: phase dead when current and voltage both low
// RULE2: pole-dead thresholds are fixed constants
// RULE3: flag each dead phase plus any-dead
// RULE4: all phases dead raises all-dead flag
// RULE5: VT failure suppresses measured pole-dead
// RULE6: breaker-open input forces pole dead
// RULE7: VT failure never suppresses breaker-open pole-dead
// RULE8: checks disabled: off flag, settings hidden
// RULE9: side dead when voltage below dead setting
// RULE10: side live when voltage above live setting
// RULE11: one threshold pair for both sides
// RULE12: reference voltage from six selectable connections
// RULE13: side setting places main input, default line
// RULE14: stage one needs slip and angle within limits
// RULE15: close permitted if either enabled stage passes
// RULE16: stages withheld by selected blocking conditions
// RULE17: stage two needs angle magnitude decreasing
// RULE18: adaptive stage two fires at predicted zero
// RULE19: slip is angle change per tick
// RULE20: split alarm near 180 degrees, same frequency
// RULE21: stage two alone has predictive slip option
// RULE22: frequency plus timer needs both limits
// RULE23: flags re-evaluated once per tick, held between; sync_function_off_flag follows the control bit at once
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "pdsc_defines.svh"
module pdsc_top #(
   parameter int TICK_CYCLES = `PDSC_TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire pdsc_pkg::pdsc_mag_type phase_current [3],
   input wire pdsc_pkg::pdsc_mag_type phase_voltage [3],
   input wire pdsc_pkg::pdsc_mag_type line_line_voltage [3],
   input wire pdsc_pkg::pdsc_mag_type sync_input_voltage,
   input wire logic [15:0] phase_angle_diff,
   input wire logic vt_failure_slow_inhibit,
   input wire logic breaker_open_three_phase,
   output logic [2:0] pole_dead,
   output logic any_pole_dead,
   output logic all_poles_dead,
   output logic dead_bus,
   output logic dead_line,
   output logic live_bus,
   output logic live_line,
   output logic stage_one_permit,
   output logic stage_two_permit,
   output logic close_permit,
   output logic split_alarm,
   output logic sync_function_off_flag
);
   import pdsc_pkg::*;

   if (TICK_CYCLES < 2) begin : g_chk
      $error("TICK_CYCLES must be at least 2");
   end

   pdsc_state_type st_reg;
   pdsc_state_type st_next;

   // Angles are binary: 16'h8000 is half a turn, so magnitude fits 16 bits unsigned
   function automatic logic [15:0] mag16(input logic [15:0] a);
      mag16 = a[15] ? 16'(~a + 16'h0001) : a;
   endfunction

   // RULE12: six reference connections
   function automatic logic [15:0] ref_select(input logic [2:0] sel, input logic [15:0] ph [3],
                                              input logic [15:0] pp [3]);
      logic [15:0] r;
      r = 16'h0000;
      unique case (sel)
         3'h0: r = pp[0];
         3'h1: r = pp[1];
         3'h2: r = pp[2];
         3'h3: r = ph[0];
         3'h4: r = ph[1];
         3'h5: r = ph[2];
         default: r = 16'h0000;
      endcase
      return r;
   endfunction

   function automatic logic stage_eval(input pdsc_slip_type meth, input logic two, input logic [2:0] mask,
                                       input logic [2:0] blk, input logic [31:0] lim, input logic [7:0] hold,
                                       input logic [7:0] tset, input logic [15:0] amag, input logic [15:0] smag,
                                       input logic decr, input logic pred_hit);
      logic slip_ok;
      logic ang_ok;
      logic tmr_ok;
      logic r;
      slip_ok = smag <= lim[15:0];
      ang_ok = amag <= lim[31:16];
      tmr_ok = hold >= tset;
      r = 1'b0;
      unique case (meth)
         // RULE14: slip and angle both in limit
         SLIP_FREQ: r = ang_ok && slip_ok;
         SLIP_TIMER: r = ang_ok && tmr_ok;
         // RULE22: set slip and timer-implied slip both
         SLIP_FREQ_TIMER: r = ang_ok && slip_ok && tmr_ok;
         // RULE18: predictive; RULE21: stage one treats it as plain frequency
         SLIP_FREQ_COMP: r = two ? (slip_ok && pred_hit) : (ang_ok && slip_ok);
      endcase
      // RULE17: stage two requires closing angle
      if (two) begin
         r = r && decr;
      end
      // RULE16: selected blocking conditions
      return r && ((mask & blk) == 3'b000);
   endfunction

   logic tick;
   logic sys_on;
   logic [15:0] main_v;
   logic [15:0] bus_v;
   logic [15:0] line_v;
   logic [15:0] slip_now;
   logic [15:0] ang_mag;
   logic [15:0] slip_mag;
   logic [31:0] pred_full;
   logic pred_hit;
   logic decr;
   logic [2:0] blk;
   logic [15:0] v_diff;
   logic [2:0] meas_dead;
   logic [15:0] dead_thr;
   logic [15:0] live_thr;
   logic both_live;

   assign tick = st_reg.tick_cnt == 32'(TICK_CYCLES - 1);
   assign sys_on = st_reg.ctrl[`PDSC_CTRL_SYS_EN];
   assign main_v = ref_select(st_reg.ctrl[`PDSC_CTRL_CSSEL_LSB +: 3], phase_voltage, line_line_voltage);
   // RULE13: side setting, 0 is line side
   assign line_v = st_reg.ctrl[`PDSC_CTRL_SIDE] ? sync_input_voltage : main_v;
   assign bus_v = st_reg.ctrl[`PDSC_CTRL_SIDE] ? main_v : sync_input_voltage;
   // RULE19: slip as angle change since the last tick
   assign slip_now = phase_angle_diff - st_reg.prev_ang;
   assign ang_mag = mag16(phase_angle_diff);
   assign slip_mag = mag16(slip_now);
   assign decr = ang_mag < mag16(st_reg.prev_ang);
   // Angle expected after the breaker close time, wrapping as the angle does
   assign pred_full = {{16{phase_angle_diff[15]}}, phase_angle_diff}
                      + ({{16{slip_now[15]}}, slip_now} * {24'h000000, st_reg.diff_close[23:16]});
   // Nearest tick to the zero crossing; finer is not possible at the tick rate
   assign pred_hit = mag16(pred_full[15:0]) <= {1'b0, slip_mag[15:1]};
   assign v_diff = (bus_v > line_v) ? 16'(bus_v - line_v) : 16'(line_v - bus_v);
   assign blk = {v_diff > st_reg.diff_close[15:0],
                 (bus_v < st_reg.blk_thr[31:16]) || (line_v < st_reg.blk_thr[31:16]),
                 (bus_v > st_reg.blk_thr[15:0]) || (line_v > st_reg.blk_thr[15:0])};
   // RULE11: shared thresholds for both sides
   assign dead_thr = st_reg.live_dead[15:0];
   assign live_thr = st_reg.live_dead[31:16];
   assign both_live = (bus_v > live_thr) && (line_v > live_thr);

   genvar gi;
   for (gi = 0; gi < 3; gi++) begin : g_meas
      // RULE1: RULE2: fixed thresholds, no setting
      assign meas_dead[gi] = (phase_current[gi] < `PDSC_I_DEAD_THR) && (phase_voltage[gi] < `PDSC_V_DEAD_THR);
   end

   always_comb begin
      logic s1;
      logic s2;
      logic [31:0] rd;
      s1 = 1'b0;
      s2 = 1'b0;
      rd = 32'h0000_0000;
      st_next = st_reg;
      st_next.tick_cnt = tick ? 32'h0000_0000 : 32'(st_reg.tick_cnt + 32'h0000_0001);
      st_next.brk_s1 = breaker_open_three_phase;
      st_next.brk_s2 = st_reg.brk_s1;
      if (reg_wr) begin
         unique case (reg_addr)
            `PDSC_OFS_CTRL: st_next.ctrl = {15'h0000, reg_wdata[16:0]};
            `PDSC_OFS_LIVE_DEAD: st_next.live_dead = reg_wdata;
            `PDSC_OFS_BLK_THR: st_next.blk_thr = reg_wdata;
            `PDSC_OFS_DIFF_CLOSE: st_next.diff_close = {8'h00, reg_wdata[23:0]};
            `PDSC_OFS_S1_LIM: st_next.s1_lim = reg_wdata;
            `PDSC_OFS_S2_LIM: st_next.s2_lim = reg_wdata;
            `PDSC_OFS_TIMERS: st_next.timers = {16'h0000, reg_wdata[15:0]};
            `PDSC_OFS_SPLIT_LIM: st_next.split_lim = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `PDSC_OFS_CTRL: rd = st_reg.ctrl;
            `PDSC_OFS_LIVE_DEAD: rd = st_reg.live_dead;
            `PDSC_OFS_BLK_THR: rd = st_reg.blk_thr;
            `PDSC_OFS_DIFF_CLOSE: rd = st_reg.diff_close;
            `PDSC_OFS_S1_LIM: rd = st_reg.s1_lim;
            `PDSC_OFS_S2_LIM: rd = st_reg.s2_lim;
            `PDSC_OFS_TIMERS: rd = st_reg.timers;
            `PDSC_OFS_SPLIT_LIM: rd = st_reg.split_lim;
            `PDSC_OFS_STATUS: rd = {17'h00000, st_reg.brk_s2, ~sys_on, st_reg.split, st_reg.close_ok,
                                    st_reg.s2_ok, st_reg.s1_ok, st_reg.live_line, st_reg.live_bus,
                                    st_reg.dead_line, st_reg.dead_bus, st_reg.all_dead, st_reg.any_dead,
                                    st_reg.pole_dead};
            default: rd = 32'h0000_0000;
         endcase
         // RULE8: settings group hidden while checks are off
         if (!sys_on && (reg_addr != `PDSC_OFS_CTRL) && (reg_addr != `PDSC_OFS_STATUS)) begin
            rd = 32'h0000_0000;
         end
      end
      st_next.rdata = rd;
      // RULE23: evaluation only on the tick
      if (tick) begin
         st_next.prev_ang = phase_angle_diff;
         // RULE5: RULE6: RULE7: breaker-open bypasses the VT gate
         st_next.pole_dead = (vt_failure_slow_inhibit ? 3'b000 : meas_dead) | {3{st_reg.brk_s2}};
         // RULE3: RULE4:
         st_next.any_dead = |st_next.pole_dead;
         st_next.all_dead = &st_next.pole_dead;
         st_next.s1_hold = (ang_mag <= st_reg.s1_lim[31:16])
                           ? ((st_reg.s1_hold == 8'hFF) ? 8'hFF : 8'(st_reg.s1_hold + 8'h01)) : 8'h00;
         st_next.s2_hold = (ang_mag <= st_reg.s2_lim[31:16] && decr)
                           ? ((st_reg.s2_hold == 8'hFF) ? 8'hFF : 8'(st_reg.s2_hold + 8'h01)) : 8'h00;
         s1 = stage_eval(pdsc_slip_type'(st_reg.ctrl[`PDSC_CTRL_S1_METH_LSB +: 2]), 1'b0,
                         st_reg.ctrl[`PDSC_CTRL_S1_MASK_LSB +: 3], blk, st_reg.s1_lim, st_next.s1_hold,
                         st_reg.timers[7:0], ang_mag, slip_mag, decr, pred_hit);
         s2 = stage_eval(pdsc_slip_type'(st_reg.ctrl[`PDSC_CTRL_S2_METH_LSB +: 2]), 1'b1,
                         st_reg.ctrl[`PDSC_CTRL_S2_MASK_LSB +: 3], blk, st_reg.s2_lim, st_next.s2_hold,
                         st_reg.timers[15:8], ang_mag, slip_mag, decr, pred_hit);
         // RULE8: all system-check flags drop while off
         // RULE9: dead below setting
         st_next.dead_bus = sys_on && (bus_v < dead_thr);
         st_next.dead_line = sys_on && (line_v < dead_thr);
         // RULE10: live above setting
         st_next.live_bus = sys_on && (bus_v > live_thr);
         st_next.live_line = sys_on && (line_v > live_thr);
         st_next.s1_ok = sys_on && both_live && st_reg.ctrl[`PDSC_CTRL_S1_EN] && s1;
         st_next.s2_ok = sys_on && both_live && st_reg.ctrl[`PDSC_CTRL_S2_EN] && s2;
         // RULE15: either stage grants
         st_next.close_ok = st_next.s1_ok || st_next.s2_ok;
         // RULE20: same frequency, angle near half a turn
         st_next.split = sys_on && both_live && (slip_mag <= st_reg.split_lim[15:0])
                         && (ang_mag >= 16'(`PDSC_ANGLE_HALF_TURN - st_reg.split_lim[31:16]));
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
         st_reg.ctrl <= `PDSC_CTRL_RST;
         st_reg.live_dead <= `PDSC_LIVE_DEAD_RST;
         st_reg.blk_thr <= `PDSC_BLK_THR_RST;
         st_reg.diff_close <= `PDSC_DIFF_CLOSE_RST;
         st_reg.s1_lim <= `PDSC_S1_LIM_RST;
         st_reg.s2_lim <= `PDSC_S2_LIM_RST;
         st_reg.timers <= `PDSC_TIMERS_RST;
         st_reg.split_lim <= `PDSC_SPLIT_LIM_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign pole_dead = st_reg.pole_dead;
   assign any_pole_dead = st_reg.any_dead;
   assign all_poles_dead = st_reg.all_dead;
   assign dead_bus = st_reg.dead_bus;
   assign dead_line = st_reg.dead_line;
   assign live_bus = st_reg.live_bus;
   assign live_line = st_reg.live_line;
   assign stage_one_permit = st_reg.s1_ok;
   assign stage_two_permit = st_reg.s2_ok;
   assign close_permit = st_reg.close_ok;
   assign split_alarm = st_reg.split;
   assign sync_function_off_flag = ~sys_on;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   property p_meas_dead;
      tick && !vt_failure_slow_inhibit && meas_dead[0] |=> pole_dead[0] && any_pole_dead;
   endproperty
   a_meas_dead: assert property (p_meas_dead) else $error("measured dead phase not flagged"); // RULE1

   property p_brk_forces;
      tick && st_reg.brk_s2 |=> pole_dead == 3'b111 && all_poles_dead;
   endproperty
   a_brk_forces: assert property (p_brk_forces) else $error("breaker open did not force dead"); // RULE7

   property p_vts_block;
      tick && vt_failure_slow_inhibit && !st_reg.brk_s2 |=> pole_dead == 3'b000 && !any_pole_dead;
   endproperty
   a_vts_block: assert property (p_vts_block) else $error("VT failure did not suppress"); // RULE5

   // The tick counter bounds the wait; here only the two-stage synchroniser delay is checked
   property p_brk_sync;
      $rose(breaker_open_three_phase) |-> ##2 st_reg.brk_s2;
   endproperty
   a_brk_sync: assert property (p_brk_sync) else $error("breaker open not seen after sync"); // RULE6

   property p_all_any;
      all_poles_dead |-> any_pole_dead && pole_dead == 3'b111;
   endproperty
   a_all_any: assert property (p_all_any) else $error("all-dead without any-dead"); // RULE4

   property p_off;
      tick && sync_function_off_flag |=> !close_permit && !live_bus && !dead_line && !split_alarm;
   endproperty
   a_off: assert property (p_off) else $error("checks active while off"); // RULE8

   property p_dead_bus;
      tick && sys_on && bus_v < dead_thr |=> dead_bus && !live_bus;
   endproperty
   a_dead_bus: assert property (p_dead_bus) else $error("dead bus not flagged"); // RULE9

   property p_live_line;
      tick && sys_on && line_v > live_thr |=> live_line && !dead_line;
   endproperty
   a_live_line: assert property (p_live_line) else $error("live line not flagged"); // RULE10

   property p_s2_decr;
      tick && !decr |=> !stage_two_permit;
   endproperty
   a_s2_decr: assert property (p_s2_decr) else $error("stage two with growing angle"); // RULE17

   property p_hold;
      !tick |=> $stable(close_permit) && $stable(pole_dead) && $stable(split_alarm);
   endproperty
   a_hold: assert property (p_hold) else $error("flag moved between ticks"); // RULE23

   property p_either;
      close_permit |-> stage_one_permit || stage_two_permit;
   endproperty
   a_either: assert property (p_either) else $error("close without a stage"); // RULE15

   c_any_dead: cover property (tick ##1 any_pole_dead && !all_poles_dead);
   c_close: cover property (tick ##1 close_permit);
   c_split: cover property (tick ##1 split_alarm);
   c_stage_two: cover property (tick ##1 stage_two_permit && !stage_one_permit);
endmodule

// ===== core/pdsc_defines.svh
// Constants for the pole-dead and system-check block: offsets, fields, resets, timing
`ifndef PDSC_DEFINES_SVH
`define PDSC_DEFINES_SVH
`define PDSC_CLK_PERIOD_NS 25
`define PDSC_TICK_TIME_NS 10000000
`define PDSC_TICK_CYCLES (`PDSC_TICK_TIME_NS / `PDSC_CLK_PERIOD_NS)
`define PDSC_I_DEAD_THR 16'h0100
`define PDSC_V_DEAD_THR 16'h0800
`define PDSC_ANGLE_HALF_TURN 16'h8000
`define PDSC_OFS_CTRL 8'h00
`define PDSC_OFS_LIVE_DEAD 8'h04
`define PDSC_OFS_BLK_THR 8'h08
`define PDSC_OFS_DIFF_CLOSE 8'h0C
`define PDSC_OFS_S1_LIM 8'h10
`define PDSC_OFS_S2_LIM 8'h14
`define PDSC_OFS_TIMERS 8'h18
`define PDSC_OFS_SPLIT_LIM 8'h1C
`define PDSC_OFS_STATUS 8'h20
`define PDSC_CTRL_SYS_EN 0
`define PDSC_CTRL_SIDE 1
`define PDSC_CTRL_CSSEL_LSB 2
`define PDSC_CTRL_S1_METH_LSB 5
`define PDSC_CTRL_S2_METH_LSB 7
`define PDSC_CTRL_S1_EN 9
`define PDSC_CTRL_S2_EN 10
`define PDSC_CTRL_S1_MASK_LSB 11
`define PDSC_CTRL_S2_MASK_LSB 14
`define PDSC_CTRL_RST 32'h0000_0601
`define PDSC_LIVE_DEAD_RST 32'h4000_1000
`define PDSC_BLK_THR_RST 32'h2000_F000
`define PDSC_DIFF_CLOSE_RST 32'h0004_1000
`define PDSC_S1_LIM_RST 32'h1555_0010
`define PDSC_S2_LIM_RST 32'h071C_0040
`define PDSC_TIMERS_RST 32'h0000_0101
`define PDSC_SPLIT_LIM_RST 32'h1555_0010
`endif

// ===== core/pdsc_pkg.sv
// Types shared by the pole-dead and system-check block
package pdsc_pkg;
   typedef logic [15:0] pdsc_mag_type;
   typedef enum logic [1:0] {SLIP_FREQ, SLIP_TIMER, SLIP_FREQ_TIMER, SLIP_FREQ_COMP} pdsc_slip_type;
   typedef struct packed {
      logic [31:0] tick_cnt;
      logic brk_s1;
      logic brk_s2;
      logic [31:0] ctrl;
      logic [31:0] live_dead;
      logic [31:0] blk_thr;
      logic [31:0] diff_close;
      logic [31:0] s1_lim;
      logic [31:0] s2_lim;
      logic [31:0] timers;
      logic [31:0] split_lim;
      logic [31:0] rdata;
      logic [15:0] prev_ang;
      logic [7:0] s1_hold;
      logic [7:0] s2_hold;
      logic [2:0] pole_dead;
      logic any_dead;
      logic all_dead;
      logic dead_bus;
      logic dead_line;
      logic live_bus;
      logic live_line;
      logic s1_ok;
      logic s2_ok;
      logic close_ok;
      logic split;
   } pdsc_state_type;
endpackage

// ===== verif/pdsc_fe.sv
// Measurement front end and breaker contact model for the pole-dead block
`timescale 1ns/1ps
module pdsc_fe #(
   parameter int TICK_CYCLES = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   output pdsc_pkg::pdsc_mag_type phase_current [3],
   output pdsc_pkg::pdsc_mag_type phase_voltage [3],
   output pdsc_pkg::pdsc_mag_type line_line_voltage [3],
   output pdsc_pkg::pdsc_mag_type sync_input_voltage,
   output logic [15:0] phase_angle_diff,
   output logic breaker_open_three_phase,
   output logic tick
);
   import pdsc_pkg::*;
   int cnt;
   logic [15:0] slip;
   assign tick = (cnt == TICK_CYCLES - 1);
   initial begin
      phase_current = '{default: 16'h1000};
      phase_voltage = '{default: 16'h5000};
      line_line_voltage = '{default: 16'h5000};
      sync_input_voltage = 16'h5000;
      phase_angle_diff = 16'h0000;
      slip = 16'h0000;
      breaker_open_three_phase = 1'b0;
   end
   // Angle steps only on the period edge, so every evaluation sees one clean slip step
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
      end else begin
         cnt <= tick ? 0 : cnt + 1;
         if (tick)
            phase_angle_diff <= phase_angle_diff + slip;
      end
   end
   task set_ph(input int k, input pdsc_mag_type i, input pdsc_mag_type v);
      phase_current[k] <= i;
      phase_voltage[k] <= v;
   endtask
   task set_ll(input int k, input pdsc_mag_type v);
      line_line_voltage[k] <= v;
   endtask
   task set_sync(input pdsc_mag_type v);
      sync_input_voltage <= v;
   endtask
   task set_ang(input logic [15:0] a, input logic [15:0] s);
      phase_angle_diff <= a;
      slip <= s;
   endtask
   task set_brk(input logic b);
      breaker_open_three_phase <= b;
   endtask
endmodule

// ===== verif/pdsc_top_tb.sv
// Self-checking bench for the pole-dead and system-check block
`timescale 1ns/1ps
`include "pdsc_defines.svh"
module pdsc_top_tb;
   import pdsc_pkg::*;
   localparam int TCK = 16;
   logic mclk;
   logic rst_b;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic vt_fail;
   pdsc_mag_type cur [3];
   pdsc_mag_type vol [3];
   pdsc_mag_type llv [3];
   pdsc_mag_type syncv;
   logic [15:0] ang;
   logic brk;
   logic tick;
   wire [12:0] flg;
   wire off_flag;
   int fail_count;
   int checked;
   int k;
   logic [31:0] rst_val [8];
   logic [15:0] bv [4];
   logic [15:0] lv [4];
   logic [15:0] ta [4];
   logic [15:0] ts [4];
   logic [3:0] tsc [4];
   pdsc_fe #(.TICK_CYCLES(TCK)) u_pdsc_fe (
      .mclk(mclk), .rst_b(rst_b), .phase_current(cur), .phase_voltage(vol),
      .line_line_voltage(llv), .sync_input_voltage(syncv), .phase_angle_diff(ang),
      .breaker_open_three_phase(brk), .tick(tick)
   );
   pdsc_top #(.TICK_CYCLES(TCK)) u_pdsc_top (
      .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_current(cur),
      .phase_voltage(vol), .line_line_voltage(llv), .sync_input_voltage(syncv),
      .phase_angle_diff(ang), .vt_failure_slow_inhibit(vt_fail), .breaker_open_three_phase(brk),
      .pole_dead(flg[2:0]), .any_pole_dead(flg[3]), .all_poles_dead(flg[4]), .dead_bus(flg[5]),
      .dead_line(flg[6]), .live_bus(flg[7]), .live_line(flg[8]), .stage_one_permit(flg[9]),
      .stage_two_permit(flg[10]), .close_permit(flg[11]), .split_alarm(flg[12]),
      .sync_function_off_flag(off_flag)
   );
   task complete_run;
      $display("Checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // Tick seen right after an edge belongs to the cycle that edge closed
   task tick_wait;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (tick !== 1'b1 && n < 4 * TCK);
      if (n >= 4 * TCK) begin
         fail_count++;
         complete_run;
      end
      #1;
   endtask
   task ev(input logic [31:0] exp);
      tick_wait;
      chk({19'h0, flg}, exp);
   endtask
   function logic [31:0] ex(input logic [2:0] pd, input logic [3:0] ld, input logic [3:0] sc);
      return {19'h0, sc, ld, &pd, |pd, pd};
   endfunction
   task sides(input logic [15:0] b, input logic [15:0] l);
      @(posedge mclk);
      u_pdsc_fe.set_sync(b);
      u_pdsc_fe.set_ll(0, l);
   endtask
   task angle(input logic [15:0] a, input logic [15:0] s);
      @(posedge mclk);
      u_pdsc_fe.set_ang(a, s);
      tick_wait;
   endtask
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      rst_val = '{`PDSC_CTRL_RST, `PDSC_LIVE_DEAD_RST, `PDSC_BLK_THR_RST, `PDSC_DIFF_CLOSE_RST,
         `PDSC_S1_LIM_RST, `PDSC_S2_LIM_RST, `PDSC_TIMERS_RST, `PDSC_SPLIT_LIM_RST};
      bv = '{16'hF100, 16'h1C00, 16'h5000, 16'h1C00};
      lv = '{16'hF100, 16'h1C00, 16'h6100, 16'h1C00};
      ta = '{16'h0000, 16'h0000, 16'h1555, 16'h1556};
      ts = '{16'h0010, 16'h0011, 16'h0000, 16'h0000};
      tsc = '{4'h5, 4'h0, 4'h5, 4'h0};
      rst_b = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      vt_fail = 1'b0;
      fail_count = 0;
      checked = 0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      chk({18'h0, off_flag, flg}, 32'h0);
      for (k = 0; k < 8; k++)
         rd(8'(k * 4), rst_val[k]);
      rd(8'h24, 32'h0);
      rd(8'h06, 32'h0);
      ev(ex(3'b000, 4'hC, 4'h5));
      rd(`PDSC_OFS_STATUS, ex(3'b000, 4'hC, 4'h5));
      @(posedge mclk);
      u_pdsc_fe.set_ph(0, 16'h00FF, 16'h07FF);
      u_pdsc_fe.set_ph(1, 16'h00FF, 16'h0800);
      u_pdsc_fe.set_ph(2, 16'h0100, 16'h0000);
      ev(ex(3'b001, 4'hC, 4'h5));
      @(posedge mclk);
      u_pdsc_fe.set_ph(0, 16'h1000, 16'h5000);
      repeat (4) @(posedge mclk);
      #1;
      chk({19'h0, flg}, ex(3'b001, 4'hC, 4'h5));
      @(posedge mclk);
      for (k = 0; k < 3; k++)
         u_pdsc_fe.set_ph(k, 16'h0000, 16'h0000);
      ev(ex(3'b111, 4'hC, 4'h5));
      @(posedge mclk);
      vt_fail <= 1'b1;
      ev(ex(3'b000, 4'hC, 4'h5));
      @(posedge mclk);
      u_pdsc_fe.set_brk(1'b1);
      ev(ex(3'b111, 4'hC, 4'h5));
      rd(`PDSC_OFS_STATUS, 32'h4000 | ex(3'b111, 4'hC, 4'h5));
      @(posedge mclk);
      vt_fail <= 1'b0;
      for (k = 0; k < 3; k++)
         u_pdsc_fe.set_ph(k, 16'h1000, 16'h5000);
      ev(ex(3'b111, 4'hC, 4'h5));
      @(posedge mclk);
      u_pdsc_fe.set_brk(1'b0);
      ev(ex(3'b000, 4'hC, 4'h5));
      // Only the selected source is live, so a wrong selection shows as a dead line
      for (k = 0; k < 6; k++) begin
         wr(`PDSC_OFS_CTRL, 32'(`PDSC_CTRL_RST | (k << `PDSC_CTRL_CSSEL_LSB)));
         @(posedge mclk);
         for (int j = 0; j < 3; j++) begin
            u_pdsc_fe.set_ll(j, (k == j) ? 16'h5000 : 16'h0800);
            u_pdsc_fe.set_ph(j, 16'h1000, (k == j + 3) ? 16'h5000 : 16'h0800);
         end
         ev(ex(3'b000, 4'hC, 4'h5));
      end
      wr(`PDSC_OFS_CTRL, `PDSC_CTRL_RST);
      @(posedge mclk);
      for (k = 0; k < 3; k++) begin
         u_pdsc_fe.set_ll(k, 16'h5000);
         u_pdsc_fe.set_ph(k, 16'h1000, 16'h5000);
      end
      sides(16'h0800, 16'h5000);
      ev(ex(3'b000, 4'h9, 4'h0));
      wr(`PDSC_OFS_CTRL, `PDSC_CTRL_RST | 32'h2);
      ev(ex(3'b000, 4'h6, 4'h0));
      wr(`PDSC_OFS_CTRL, `PDSC_CTRL_RST);
      sides(16'h1000, 16'h4000);
      ev(ex(3'b000, 4'h0, 4'h0));
      sides(16'h5000, 16'h5000);
      angle(16'h0300, 16'hFFE0);
      ev(ex(3'b000, 4'hC, 4'h6));
      angle(16'h0300, 16'h0020);
      ev(ex(3'b000, 4'hC, 4'h0));
      for (k = 0; k < 4; k++) begin
         angle(ta[k], ts[k]);
         ev(ex(3'b000, 4'hC, tsc[k]));
      end
      angle(16'h0000, 16'h0000);
      wr(`PDSC_OFS_LIVE_DEAD, 32'h1800_1000);
      // Last case masks overvoltage only while undervoltage is present, so it must pass
      for (k = 0; k < 4; k++) begin
         wr(`PDSC_OFS_CTRL, 32'(`PDSC_CTRL_RST | (1 << (`PDSC_CTRL_S1_MASK_LSB + k % 3))));
         sides(bv[k], lv[k]);
         ev(ex(3'b000, 4'hC, (k == 3) ? 4'h5 : 4'h0));
      end
      wr(`PDSC_OFS_LIVE_DEAD, `PDSC_LIVE_DEAD_RST);
      wr(`PDSC_OFS_CTRL, `PDSC_CTRL_RST);
      sides(16'h5000, 16'h5000);
      angle(16'h6AAB, 16'h0000);
      ev(ex(3'b000, 4'hC, 4'h8));
      angle(16'h6AAA, 16'h0000);
      ev(ex(3'b000, 4'hC, 4'h0));
      wr(`PDSC_OFS_CTRL, 32'(`PDSC_CTRL_RST | (3 << `PDSC_CTRL_S2_METH_LSB)));
      angle(16'h0100, 16'hFFE0);
      repeat (2) tick_wait;
      ev(ex(3'b000, 4'hC, 4'h0));
      ev(ex(3'b000, 4'hC, 4'h6));
      ev(ex(3'b000, 4'hC, 4'h0));
      wr(`PDSC_OFS_CTRL, 32'h0000_0600);
      #1;
      chk({31'h0, off_flag}, 32'h1);
      wr(`PDSC_OFS_LIVE_DEAD, 32'h3000_1000);
      rd(`PDSC_OFS_LIVE_DEAD, 32'h0);
      wr(`PDSC_OFS_CTRL, `PDSC_CTRL_RST);
      rd(`PDSC_OFS_LIVE_DEAD, 32'h3000_1000);
      chk({31'h0, off_flag}, 32'h0);
      complete_run;
   end
endmodule
